// *** rtl/wicem_deglitch.v ***
`timescale 1ns/1ps
module wicem_deglitch #(
   parameter [13:0] SHORT_CYC = 14'd1875,
   parameter [13:0] LONG_CYC = 14'd8125
) (
   input wire clk_in,
   input wire rst_in,
   input wire level_in,
   input wire long_sel_in,
   output reg level_out
);
   reg [13:0] count;
   wire [13:0] limit;

   assign limit = long_sel_in ? LONG_CYC : SHORT_CYC; // R13

   // a differing level must persist limit cycles; any bounce restarts
   always @(posedge clk_in) begin
      if (rst_in) begin
         count <= 14'h0000;
         level_out <= 1'b0;
      end else if (level_in == level_out) begin
         count <= 14'h0000; // R14
      end else if (count >= limit - 14'h0001) begin
         count <= 14'h0000;
         level_out <= level_in; // R14
      end else begin
         count <= count + 14'h0001;
      end
   end
endmodule // wicem_deglitch

// *** rtl/wicem_sync2.v ***
`timescale 1ns/1ps
module wicem_sync2 #(
   parameter W = 1
) (
   input wire clk_in,
   input wire rst_in,
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] meta;

   always @(posedge clk_in) begin
      if (rst_in) begin
         meta <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule // wicem_sync2

// *** rtl/wicem_top.v ***
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "wicem_defines.vh"
module wicem_top #(
   parameter [13:0] DGLT_LONG_CYC = `WICEM_DGLT_LONG_CYC
) (
   input wire CLK_IN,
   input wire RST_IN,
   input wire [7:0] ADDR_IN,
   input wire [15:0] WDATA_IN,
   input wire WR_IN,
   input wire RD_IN,
   output reg [15:0] RDATA_OUT,
   input wire [3:0] SUPPLY_FAULT_IN,
   input wire [4:0] COMM_ERR_IN,
   input wire LOW_POWER_IN,
   input wire [3:0] HV_WAKE_IN,
   input wire [2:0] LV_WAKE_IN,
   output reg [3:0] COMP_EN_OUT,
   output reg [3:0] CYCLIC_SEL_OUT,
   output reg WAKEUP_OUT,
   output reg IRQ_OUT
);

   ////////////////////////////////////////////////////////////////////////
   // registers and wires

   localparam [13:0] SHORT_CYC = `WICEM_DGLT_SHORT_CYC;

   reg [15:0] err_mask;
   reg [15:0] wake_cfg;
   reg [15:0] err_flag;
   reg [15:0] wake_en;
   reg [15:0] wake_flag;
   reg [3:0] supply_prev;
   reg [3:0] hv_prev;
   reg [2:0] lv_prev;
   reg [15:0] next_rdata;
   reg [15:0] next_err_flag;
   reg [15:0] next_wake_flag;
   wire [6:0] wake_evt;
   wire [6:0] wake_hit;
   wire [6:0] irq_hit;
   wire [3:0] next_comp_en;
   wire [3:0] next_cyclic_sel;

   wire [3:0] supply_sync;
   wire [3:0] hv_sync;
   wire [2:0] lv_sync;
   wire [3:0] hv_filt;
   wire [3:0] supply_rise;
   wire [15:0] err_evt;
   wire [15:0] err_pend;
   wire [2:0] lv_pol;
   wire [3:0] filter_sel;
   wire wr_err_mask;
   wire wr_wake_cfg;
   wire wr_err_flag;
   wire wr_wake_en;
   wire wr_wake_flag;
   wire sel_err_mask;
   wire sel_wake_cfg;
   wire sel_err_flag;
   wire sel_wake_en;
   wire sel_wake_flag;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   wicem_sync2 #(
      .W(4)
   ) u_supply_sync (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .async_in(SUPPLY_FAULT_IN),
      .sync_out(supply_sync)
   );

   wicem_sync2 #(
      .W(4)
   ) u_hv_sync (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .async_in(HV_WAKE_IN),
      .sync_out(hv_sync)
   );

   wicem_sync2 #(
      .W(3)
   ) u_lv_sync (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .async_in(LV_WAKE_IN),
      .sync_out(lv_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // deglitch filters, one per hv wake input

   assign filter_sel = wake_cfg[`WICEM_CFG_FILTER_LSB +: 4];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_hv
         wicem_deglitch #(
            .SHORT_CYC(SHORT_CYC),
            .LONG_CYC(DGLT_LONG_CYC)
         ) u_dglt (
            .clk_in(CLK_IN),
            .rst_in(RST_IN),
            .level_in(hv_sync[gi]),
            .long_sel_in(filter_sel[gi]), // R13
            .level_out(hv_filt[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // register write decode

   // one compare per mapped register
   assign sel_err_mask = (ADDR_IN == `WICEM_ADDR_ERR_MASK);
   assign sel_wake_cfg = (ADDR_IN == `WICEM_ADDR_WAKE_CFG);
   assign sel_err_flag = (ADDR_IN == `WICEM_ADDR_ERR_FLAG);
   assign sel_wake_en = (ADDR_IN == `WICEM_ADDR_WAKE_EN);
   assign sel_wake_flag = (ADDR_IN == `WICEM_ADDR_WAKE_FLAG);

   // the strobe qualifies each select
   assign wr_err_mask = WR_IN && sel_err_mask;
   assign wr_wake_cfg = WR_IN && sel_wake_cfg;
   assign wr_err_flag = WR_IN && sel_err_flag;
   assign wr_wake_en = WR_IN && sel_wake_en;
   assign wr_wake_flag = WR_IN && sel_wake_flag;

   // error mask: unused bits never take a one
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         err_mask <= `WICEM_ERR_MASK_RST; // R02
      end else if (wr_err_mask) begin
         err_mask <= WDATA_IN & `WICEM_ERR_VALID; // R08
      end
   end

   // wake configuration: bit 12 stays zero
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         wake_cfg <= `WICEM_CFG_RST; // R17
      end else if (wr_wake_cfg) begin
         wake_cfg <= WDATA_IN & `WICEM_CFG_VALID; // R09 R15 R17
      end
   end

   // wake enable pairs
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         wake_en <= `WICEM_WEN_RST;
      end else if (wr_wake_en) begin
         wake_en <= WDATA_IN & `WICEM_WEN_VALID; // R19
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error events and their sticky flags

   assign supply_rise = supply_sync & ~supply_prev;
   assign err_evt = {6'h00, COMM_ERR_IN, 1'b0, supply_rise};

   always @* begin
      next_err_flag = err_flag;
      if (wr_err_flag) begin
         next_err_flag = next_err_flag & ~WDATA_IN; // R18
      end
      // a new event wins over a clear in the same cycle
      next_err_flag = (next_err_flag | err_evt) & `WICEM_ERR_VALID;
   end

   // a set mask bit keeps its flag away from the interrupt line
   assign err_pend = err_flag & ~err_mask; // R01 R03 R04 R05 R06 R07

   ////////////////////////////////////////////////////////////////////////
   // wake detection

   assign lv_pol = wake_cfg[`WICEM_CFG_LVPOL_LSB +: 3];

   // per hv input: the mode field picks which filtered edge counts
   genvar hi;
   generate
      for (hi = 0; hi < 4; hi = hi + 1) begin : g_hv_evt
         wire [1:0] mode;
         wire rise;
         wire fall;
         wire change;
         reg evt;

         assign mode = wake_cfg[2*hi +: 2]; // R09
         // edges of the filtered level only
         assign rise = hv_filt[hi] & ~hv_prev[hi];
         assign fall = ~hv_filt[hi] & hv_prev[hi];
         assign change = hv_filt[hi] ^ hv_prev[hi];

         always @* begin
            evt = 1'b0;
            case (mode)
               `WICEM_MODE_HIGH: begin
                  evt = rise; // R11
               end
               `WICEM_MODE_LOW: begin
                  evt = fall; // R11
               end
               `WICEM_MODE_CYCLIC: begin
                  evt = change; // R12
               end
               default: begin
                  // comparator may be off: no wake from this input
                  evt = 1'b0; // R10
               end
            endcase
         end

         assign wake_evt[hi] = evt;
      end
   endgenerate

   // per lv input: polarity bit picks the active level
   genvar li;
   generate
      for (li = 0; li < 3; li = li + 1) begin : g_lv_evt
         wire rise;
         wire fall;
         wire hit;

         assign rise = lv_sync[li] & ~lv_prev[li];
         assign fall = ~lv_sync[li] & lv_prev[li];
         // polarity one waits for the falling level
         assign hit = lv_pol[li] ? fall : rise; // R16
         assign wake_evt[4 + li] = hit;
      end
   endgenerate

   always @* begin
      next_wake_flag = wake_flag;
      if (wr_wake_flag) begin
         next_wake_flag = next_wake_flag & ~WDATA_IN; // R18
      end
      next_wake_flag = (next_wake_flag | {9'h000, wake_evt})
         & `WICEM_WFLG_VALID;
   end

   // enable bit 0 of each pair asks for wake-up, bit 1 for an interrupt
   genvar ei;
   generate
      for (ei = 0; ei < 7; ei = ei + 1) begin : g_enable
         assign wake_hit[ei] = wake_flag[ei] & wake_en[2*ei]; // R19
         assign irq_hit[ei] = wake_flag[ei] & wake_en[2*ei + 1]; // R19
      end
   endgenerate

   // per hv input: comparator power and cyclic-sense select
   genvar ci;
   generate
      for (ci = 0; ci < 4; ci = ci + 1) begin : g_comp
         wire [1:0] mode;
         wire sleep_off;
         wire cyclic;

         assign mode = wake_cfg[2*ci +: 2];
         // mode 00 powers the comparator down in low-power only
         assign sleep_off = LOW_POWER_IN && (mode == `WICEM_MODE_OFF);
         assign cyclic = (mode == `WICEM_MODE_CYCLIC);
         assign next_comp_en[ci] = ~sleep_off; // R10
         assign next_cyclic_sel[ci] = cyclic; // R12
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // status registers and outputs

   // sticky flags: a new event beats a software clear in the same cycle
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         err_flag <= 16'h0000;
         wake_flag <= 16'h0000;
      end else begin
         err_flag <= next_err_flag;
         wake_flag <= next_wake_flag;
      end
   end

   // last-cycle copies for edge detection
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         supply_prev <= 4'h0;
         hv_prev <= 4'h0;
         lv_prev <= 3'h0;
      end else begin
         supply_prev <= supply_sync;
         hv_prev <= hv_filt;
         lv_prev <= lv_sync;
      end
   end

   // every output leaves straight from a flop
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         COMP_EN_OUT <= 4'h0;
         CYCLIC_SEL_OUT <= 4'h0;
         WAKEUP_OUT <= 1'b0;
         IRQ_OUT <= 1'b0;
      end else begin
         COMP_EN_OUT <= next_comp_en;
         CYCLIC_SEL_OUT <= next_cyclic_sel;
         WAKEUP_OUT <= |wake_hit;
         IRQ_OUT <= (|err_pend) | (|irq_hit);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path: data valid the cycle after the strobe, zero otherwise

   always @* begin
      next_rdata = 16'h0000;
      if (!RD_IN) begin
         next_rdata = 16'h0000;
      end else if (ADDR_IN == `WICEM_ADDR_ERR_MASK) begin
         next_rdata = err_mask; // R08
      end else if (ADDR_IN == `WICEM_ADDR_WAKE_CFG) begin
         next_rdata = wake_cfg; // R17
      end else if (ADDR_IN == `WICEM_ADDR_ERR_FLAG) begin
         next_rdata = err_flag;
      end else if (ADDR_IN == `WICEM_ADDR_WAKE_EN) begin
         next_rdata = wake_en;
      end else if (ADDR_IN == `WICEM_ADDR_WAKE_FLAG) begin
         next_rdata = wake_flag;
      end
   end

   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         RDATA_OUT <= 16'h0000;
      end else begin
         RDATA_OUT <= next_rdata;
      end
   end

endmodule // wicem_top

// *** shared/wicem_defines.vh ***
// How it works
// R01: mask bits 0-3 set to one block supply under/over voltage interrupts.
// R02: every error mask bit resets to zero, so all error interrupts start enabled; the lv input interrupt enables reset to zero.
// R03: mask bit 5 blocks the serial peripheral request error interrupt.
// R04: mask bit 6 blocks the serial peripheral clock count error interrupt.
// R05: mask bit 7 blocks the serial peripheral crc error interrupt.
// R06: mask bit 8 blocks the two-wire bus request error interrupt.
// R07: mask bit 9 blocks the two-wire bus crc error interrupt.
// R08: error mask bit 4 and bits 10-15 read zero and ignore writes.
// R09: wake config holds two-bit mode fields for the four hv wake inputs.
// R10: mode 00 turns the input comparator off in low-power modes only.
// R11: mode 01 wakes on high level, mode 10 wakes on low level.
// R12: mode 11 selects cyclic-sense detection instead of level detection.
// R13: bits 8-11 pick each hv deglitch time: zero 15 us, one 65 us.
// R14: an hv level change counts only after lasting the whole deglitch time.
// R15: bits 13, 14, 15 hold polarity of lv io a, lv io b, lv input.
// R16: lv polarity zero wakes on high level, one wakes on low level.
// R17: wake config bit 12 reads zero; other fields restore on reset.
// R18: software clears a latched flag by writing one; masks only gate irq.
// R19: per-input two-bit enable picks wake-up, interrupt, both or neither.
`ifndef WICEM_DEFINES_VH
`define WICEM_DEFINES_VH

// register offsets (byte addresses)
`define WICEM_ADDR_ERR_MASK 8'h00
`define WICEM_ADDR_WAKE_CFG 8'h04
`define WICEM_ADDR_ERR_FLAG 8'h08
`define WICEM_ADDR_WAKE_EN 8'h0C
`define WICEM_ADDR_WAKE_FLAG 8'h10

// writable bits and reset values
`define WICEM_ERR_VALID 16'h03EF
`define WICEM_ERR_MASK_RST 16'h0000
`define WICEM_CFG_VALID 16'hEFFF
`define WICEM_CFG_RST 16'h0005
`define WICEM_WEN_VALID 16'h3FFF
`define WICEM_WEN_RST 16'h00FF
`define WICEM_WFLG_VALID 16'h007F

// field positions
`define WICEM_ERR_SUPPLY_LSB 0
`define WICEM_ERR_COMM_LSB 5
`define WICEM_CFG_FILTER_LSB 8
`define WICEM_CFG_LVPOL_LSB 13
`define WICEM_WFLG_LV_LSB 4

// wake mode codes
`define WICEM_MODE_OFF 2'h0
`define WICEM_MODE_HIGH 2'h1
`define WICEM_MODE_LOW 2'h2
`define WICEM_MODE_CYCLIC 2'h3

// deglitch timing
`define WICEM_CLK_PERIOD_NS 8
`define WICEM_DGLT_SHORT_NS 15000
`define WICEM_DGLT_LONG_NS 65000
// filter lengths in clock cycles at the period above, sized for the counter
`define WICEM_DGLT_SHORT_CYC 14'h0753
`define WICEM_DGLT_LONG_CYC 14'h1FBD

`endif

// *** test/wicem_props.sv ***
`timescale 1ns/1ps
module wicem_props #(
   parameter [13:0] DGLT_LONG_CYC = 14'd40
) (
   input wire CLK_IN,
   input wire RST_IN,
   input wire [7:0] ADDR_IN,
   input wire [15:0] WDATA_IN,
   input wire WR_IN,
   input wire RD_IN,
   input wire [15:0] RDATA_OUT,
   input wire [3:0] SUPPLY_FAULT_IN,
   input wire [4:0] COMM_ERR_IN,
   input wire LOW_POWER_IN,
   input wire [3:0] COMP_EN_OUT,
   input wire [3:0] CYCLIC_SEL_OUT,
   input wire WAKEUP_OUT,
   input wire IRQ_OUT
);
   // shadow copies of the two configuration registers
   reg [15:0] msk;
   reg [15:0] cfg;
   wire [3:0] off;
   wire [3:0] cyc;
   assign off = {cfg[7:6] == 2'h0, cfg[5:4] == 2'h0, cfg[3:2] == 2'h0,
      cfg[1:0] == 2'h0};
   assign cyc = {cfg[7:6] == 2'h3, cfg[5:4] == 2'h3, cfg[3:2] == 2'h3,
      cfg[1:0] == 2'h3};
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         msk <= 16'h0000;
         cfg <= 16'h0005;
      end else if (WR_IN && ADDR_IN == 8'h00) begin
         msk <= WDATA_IN & 16'h03EF;
      end else if (WR_IN && ADDR_IN == 8'h04) begin
         cfg <= WDATA_IN & 16'hEFFF;
      end
   end
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   property p_mask_read;
      $past(RD_IN) && $past(ADDR_IN) == 8'h00 |-> RDATA_OUT == $past(msk);
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read");
   property p_cfg_read;
      $past(RD_IN) && $past(ADDR_IN) == 8'h04 |-> RDATA_OUT == $past(cfg);
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("cfg read");
   property p_idle;
      !$past(RD_IN) |-> RDATA_OUT == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("read data idle");
   property p_comp;
      !$past(RST_IN) |->
         COMP_EN_OUT == ~($past(off) & {4{$past(LOW_POWER_IN)}});
   endproperty
   a_comp: assert property (p_comp) else $error("comparator enable");
   property p_cyc;
      !$past(RST_IN) |-> CYCLIC_SEL_OUT == $past(cyc);
   endproperty
   a_cyc: assert property (p_cyc) else $error("cyclic select");
   property p_comm;
      |(COMM_ERR_IN & ~msk[9:5]) ##1 !WR_IN |-> ##1 IRQ_OUT;
   endproperty
   a_comm: assert property (p_comm) else $error("comm irq");
   property p_supply;
      |(SUPPLY_FAULT_IN & ~$past(SUPPLY_FAULT_IN) & ~msk[3:0])
         ##1 (!WR_IN) [*6] |-> IRQ_OUT;
   endproperty
   a_supply: assert property (p_supply) else $error("supply irq");
   property p_reset;
      disable iff (1'b0) RST_IN |=> !IRQ_OUT && !WAKEUP_OUT &&
         COMP_EN_OUT == 4'h0 && CYCLIC_SEL_OUT == 4'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("reset outputs");
   c_comm: cover property (|COMM_ERR_IN ##2 IRQ_OUT);
   c_wake: cover property (WAKEUP_OUT);
   c_lp: cover property (LOW_POWER_IN ##1 COMP_EN_OUT != 4'hF);
endmodule // wicem_props
bind wicem_top wicem_props #(.DGLT_LONG_CYC(DGLT_LONG_CYC)) props_u (
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
   .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
   .RDATA_OUT(RDATA_OUT), .SUPPLY_FAULT_IN(SUPPLY_FAULT_IN),
   .COMM_ERR_IN(COMM_ERR_IN), .LOW_POWER_IN(LOW_POWER_IN),
   .COMP_EN_OUT(COMP_EN_OUT), .CYCLIC_SEL_OUT(CYCLIC_SEL_OUT),
   .WAKEUP_OUT(WAKEUP_OUT), .IRQ_OUT(IRQ_OUT));

// *** test/wicem_top_bench.sv ***
`timescale 1ns/1ps
module wicem_top_bench;
   reg clk, rst, wr, rd, lp;
   reg [7:0] addr;
   reg [15:0] wdata;
   reg [3:0] sf, hv;
   reg [4:0] ce;
   reg [2:0] lv;
   wire [15:0] rdata;
   wire [3:0] hvw, comp, cyc;
   wire [2:0] lvw;
   wire wu, irq;
   integer mismatches, tests_run, i, p;
   wicem_wake_src src_u (.clk_in(clk), .hv_in(hv), .lv_in(lv),
      .hv_out(hvw), .lv_out(lvw));
   wicem_top #(.DGLT_LONG_CYC(14'd40)) dut_u (.CLK_IN(clk), .RST_IN(rst),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdata), .SUPPLY_FAULT_IN(sf), .COMM_ERR_IN(ce),
      .LOW_POWER_IN(lp), .HV_WAKE_IN(hvw), .LV_WAKE_IN(lvw),
      .COMP_EN_OUT(comp), .CYCLIC_SEL_OUT(cyc), .WAKEUP_OUT(wu),
      .IRQ_OUT(irq));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task chk(input [15:0] s, input [15:0] e);
      begin
         tests_run = tests_run + 1;
         if (s !== e) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: got %h expected %h", $time, s, e);
         end
      end
   endtask
   task w(input integer n);
      begin
         repeat (n) @(posedge clk);
      end
   endtask
   task reg_wr(input [7:0] a, input [15:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task reg_rd(input [7:0] a, input [15:0] e);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 chk(rdata, e);
      end
   endtask
   task give_verdict;
      begin
         $display("Checks %0d, mismatches %0d", tests_run, mismatches);
         if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial begin
      #200000;
      mismatches = mismatches + 1;
      give_verdict;
   end
   initial begin
      {mismatches, tests_run} = 0;
      {rst, wr, rd, lp} = 4'h8;
      {addr, wdata, sf, ce, hv, lv} = 0;
      w(12);
      rst <= 1'b0;
      reg_rd(8'h00, 16'h0000);
      reg_rd(8'h04, 16'h0005);
      reg_wr(8'h20, 16'hFFFF);
      reg_rd(8'h20, 16'h0000);
      reg_wr(8'h00, 16'hFFFF);
      reg_rd(8'h00, 16'h03EF);
      reg_wr(8'h04, 16'hFFFF);
      reg_rd(8'h04, 16'hEFFF);
      #1 chk(cyc, 4'hF);
      reg_wr(8'h04, 16'h0005);
      @(posedge clk) lp <= 1'b1;
      w(2);
      #1 chk(comp, 4'h3);
      @(posedge clk) lp <= 1'b0;
      w(2);
      #1 chk(comp, 4'hF);
      // each event masked alone: flag latches, irq only once unmasked
      for (i = 0; i < 9; i = i + 1) begin
         p = (i < 4) ? i : i + 1;
         reg_wr(8'h00, 16'h0001 << p);
         if (i < 4) sf[i] <= 1'b1;
         else ce[i - 4] <= 1'b1;
         @(posedge clk) ce <= 5'h00;
         w(8);
         #1 chk(irq, 1'b0);
         reg_wr(8'h00, 16'h0000);
         w(2);
         #1 chk(irq, 1'b1);
         reg_wr(8'h08, 16'h0001 << p);
         sf <= 4'h0;
         w(2);
         #1 chk(irq, 1'b0);
      end
      @(posedge clk) sf <= 4'h8;
      ce <= 5'h04;
      @(posedge clk) ce <= 5'h00;
      w(8);
      #1 chk(irq, 1'b1);
      reg_wr(8'h08, 16'h03EF);
      sf <= 4'h0;
      reg_wr(8'h04, 16'h0101);
      hv <= 4'h1;
      w(30);
      hv <= 4'h0;
      w(60);
      reg_rd(8'h10, 16'h0000);
      @(posedge clk) hv <= 4'h1;
      w(60);
      reg_rd(8'h10, 16'h0001);
      chk(wu, 1'b1);
      chk(irq, 1'b1);
      reg_wr(8'h10, 16'h0001);
      reg_wr(8'h04, 16'h0102);
      hv <= 4'h0;
      w(60);
      reg_rd(8'h10, 16'h0001);
      reg_wr(8'h10, 16'h0001);
      reg_wr(8'h04, 16'h0001);
      hv <= 4'h1;
      w(1000);
      reg_rd(8'h10, 16'h0000);
      w(1000);
      reg_rd(8'h10, 16'h0001);
      reg_wr(8'h10, 16'h0001);
      reg_wr(8'h04, 16'h020C);
      hv <= 4'h3;
      w(60);
      reg_rd(8'h10, 16'h0002);
      reg_wr(8'h10, 16'h0002);
      reg_wr(8'h04, 16'h0200);
      hv <= 4'h1;
      w(60);
      reg_rd(8'h10, 16'h0000);
      reg_wr(8'h04, 16'h4000);
      lv <= 3'h3;
      w(6);
      reg_rd(8'h10, 16'h0010);
      @(posedge clk) lv <= 3'h0;
      w(6);
      reg_rd(8'h10, 16'h0030);
      give_verdict;
   end
endmodule // wicem_top_bench

// *** test/wicem_wake_src.sv ***
`timescale 1ns/1ps
// wake switches and input lines; contacts settle one clock after moving
module wicem_wake_src (
   input wire clk_in,
   input wire [3:0] hv_in,
   input wire [2:0] lv_in,
   output reg [3:0] hv_out,
   output reg [2:0] lv_out
);
   always @(posedge clk_in) begin
      hv_out <= hv_in;
      lv_out <= lv_in;
   end
endmodule // wicem_wake_src
